// file: csb_system_if.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Notes on behaviour
// - ready held low while register move pending
// - register picked by low eight address lines
// - started engine raises hold request
// - no memory access before grant seen
// - bus released after every single byte
// - data multiplexed on upper address lines
// - memory access takes three clocks unwaited
// ------------------------------------------------------------
module csb_system_if
    import csb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic engineStart,
    input wire logic xferWrite,
    input wire logic [23:0] xferAddr,
    input wire logic [7:0] xferWriteData,
    output logic xferDone,
    output logic [7:0] xferReadData,
    input wire logic codecRegisterSelectN,
    input wire logic slaveReadN,
    input wire logic slaveWriteN,
    input wire logic [7:0] slaveAddr,
    input wire logic [7:0] slaveDataIn,
    output logic [7:0] slaveDataOut,
    output logic slaveDataOe,
    output logic readyN,
    output logic readyOe,
    input wire logic memReady,
    output logic busHoldRequest,
    input wire logic busHoldGrant,
    output logic [23:0] addrOut,
    output logic addrOe,
    input wire logic [7:0] upperAddrIn,
    output logic addrLatchEnable,
    output logic memReadN,
    output logic memWriteN
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_REQ = 5'b00010,
        ST_ADDR = 5'b00100,
        ST_DATA = 5'b01000,
        ST_END = 5'b10000
    } csb_state_e;

    csb_state_e state;
    logic pending;
    logic [1:0] phase;
    logic [2:0] slaveCount;
    logic slaveActive;
    logic slaveWrite;
    logic [7:0] regRead;

    // ------------------------------------------------------------
    // slave register access
    // ------------------------------------------------------------
    // select low opens a register cycle; the host drives it
    assign slaveActive = !codecRegisterSelectN;
    assign slaveWrite = slaveActive && !slaveWriteN && slaveCount == 3'(SLAVE_BUSY_CYCLES - 1);

    // busy count while the register move is pending
    always_ff @(posedge clk) begin
        if (srst || !slaveActive) begin
            slaveCount <= 3'h0;
        end else if (slaveCount != 3'(SLAVE_BUSY_CYCLES)) begin
            slaveCount <= slaveCount + 3'h1;
        end
    end

    // ready is an output only in slave mode, low until done
    assign readyOe = slaveActive;
    assign readyN = !(slaveActive && slaveCount != 3'(SLAVE_BUSY_CYCLES));
    assign slaveDataOe = slaveActive && !slaveReadN;

    // register index straight from the low address byte
    csb_reg_store uStore (
        .clk(clk),
        .srst(srst),
        .writeStrobe(slaveWrite),
        .regIndex(slaveAddr),
        .writeData(slaveDataIn),
        .readData(regRead)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            slaveDataOut <= 8'h00;
        end else begin
            slaveDataOut <= regRead;
        end
    end

    // ------------------------------------------------------------
    // master transfer engine
    // ------------------------------------------------------------
    // a start is remembered until the byte has gone out
    always_ff @(posedge clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (engineStart) begin
            pending <= 1'b1;
        end else if (state == ST_END) begin
            pending <= 1'b0;
        end
    end

    // one byte per grant; register access holds off the start of a byte
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (pending && !slaveActive) begin
                        state <= ST_REQ;
                    end
                end
                ST_REQ: begin
                    if (busHoldGrant) begin
                        state <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    state <= ST_DATA;
                end
                ST_DATA: begin
                    // ready sampled in last phase adds a wait
                    if (phase == PHASE_LAST && memReady) begin
                        state <= ST_END;
                    end
                end
                ST_END: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // phase counter across the three access clocks
    always_ff @(posedge clk) begin
        if (srst || state == ST_REQ) begin
            phase <= 2'h0;
        end else if ((state == ST_ADDR || state == ST_DATA) && phase != PHASE_LAST) begin
            phase <= phase + 2'h1;
        end
    end

    // hold request drops at the end of each byte
    assign busHoldRequest = state == ST_REQ || state == ST_ADDR || state == ST_DATA;
    // grant-qualified drive of the system lines
    assign addrOe = busHoldGrant && (state == ST_ADDR || state == ST_DATA);
    assign addrLatchEnable = state == ST_ADDR;

    // data rides the upper address byte during data phase
    always_ff @(posedge clk) begin
        if (srst) begin
            addrOut <= 24'h00_0000;
        end else if (state == ST_REQ) begin
            addrOut <= xferAddr;
        end else if ((state == ST_ADDR || state == ST_DATA) && xferWrite) begin
            // loaded in the address phase so the byte stands for the whole strobe
            addrOut <= {xferWriteData, xferAddr[15:0]};
        end
    end

    assign memReadN = !(state == ST_DATA && !xferWrite);
    assign memWriteN = !(state == ST_DATA && xferWrite);

    // read byte captured from the upper lines at completion
    always_ff @(posedge clk) begin
        if (srst) begin
            xferReadData <= 8'h00;
        end else if (state == ST_DATA && phase == PHASE_LAST && memReady && !xferWrite) begin
            xferReadData <= upperAddrIn;
        end
    end

    assign xferDone = state == ST_END;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_granted;
        state == ST_REQ && busHoldGrant;
    endsequence

    property p_noAccessWithoutGrant;
        @(posedge clk) disable iff (srst) (state == ST_REQ && !busHoldGrant) |=> state != ST_ADDR;
    endproperty
    a_noAccessWithoutGrant: assert property (p_noAccessWithoutGrant) else $error("access without grant");

    property p_threeClocks;
        @(posedge clk) disable iff (srst) s_granted ##1 (memReady [*3]) |=> state == ST_END;
    endproperty
    a_threeClocks: assert property (p_threeClocks) else $error("access not three clocks");

    property p_releasePerByte;
        @(posedge clk) disable iff (srst) xferDone |-> !busHoldRequest ##1 !busHoldRequest;
    endproperty
    a_releasePerByte: assert property (p_releasePerByte) else $error("bus kept after byte");

    property p_requestOnStart;
        @(posedge clk) disable iff (srst) (state == ST_IDLE && pending && !slaveActive) |=> busHoldRequest;
    endproperty
    a_requestOnStart: assert property (p_requestOnStart) else $error("no hold request");

    property p_readyLow;
        @(posedge clk) disable iff (srst) $fell(codecRegisterSelectN) |-> !readyN [*4] ##1 readyN;
    endproperty
    a_readyLow: assert property (p_readyLow) else $error("ready timing wrong");

    property p_waitHolds;
        @(posedge clk) disable iff (srst) (state == ST_DATA && !memReady) |=> state == ST_DATA;
    endproperty
    a_waitHolds: assert property (p_waitHolds) else $error("wait not honoured");

    property p_dataOnUpper;
        @(posedge clk) disable iff (srst) (state == ST_DATA && xferWrite) |-> addrOut[23:16] == xferWriteData;
    endproperty
    a_dataOnUpper: assert property (p_dataOnUpper) else $error("data not on upper lines");

    property p_regIndex;
        @(posedge clk) disable iff (srst) (slaveActive && slaveAddr == 8'h00 && !slaveWriteN && slaveCount == 3'h3)
            ##1 (slaveAddr == 8'h00) [*3] |-> slaveDataOut == $past(slaveDataIn, 3);
    endproperty
    a_regIndex: assert property (p_regIndex) else $error("register index wrong");
endmodule

// file: csb_pkg.sv
package csb_pkg;
    // bus cycle timing in device clocks
    localparam int CLK_MHZ = 50;
    localparam int MEM_ACCESS_CYCLES = 3;
    localparam int SLAVE_BUSY_CYCLES = 4;
    localparam logic [7:0] REG_COUNT = 8'h0010;
    localparam logic [7:0] REG_RESET_VALUE = 8'h0000;
    localparam logic [1:0] PHASE_LAST = 2'h2;
endpackage

// file: csb_reg_store.sv
`timescale 1ns/1ps
module csb_reg_store
    import csb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic writeStrobe,
    input wire logic [7:0] regIndex,
    input wire logic [7:0] writeData,
    output logic [7:0] readData
);
    logic [7:0] store [0:15];

    // ------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------
    // only sixteen words are backed; higher indices read as zero
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : gStore
            always_ff @(posedge clk) begin
                if (srst) begin
                    store[gi] <= REG_RESET_VALUE;
                end else if (writeStrobe && regIndex == 8'(gi)) begin
                    store[gi] <= writeData;
                end
            end
        end
    endgenerate

    // registered read data
    always_ff @(posedge clk) begin
        if (srst) begin
            readData <= REG_RESET_VALUE;
        end else if (regIndex < REG_COUNT) begin
            readData <= store[regIndex[3:0]];
        end else begin
            readData <= 8'h00;
        end
    end
endmodule

// file: csb_host_model.sv
`timescale 1ns/1ps
// ----------------
// host side model
// ----------------
module csb_host_model
    import csb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic busHoldRequest,
    output logic busHoldGrant,
    input wire logic memReadN,
    input wire logic memWriteN,
    output logic memReady,
    output logic [7:0] upperAddrIn,
    input wire logic [3:0] grantDelay,
    input wire logic waitOn,
    input wire logic [7:0] readByte,
    input wire logic claimSet,
    input wire logic claimClear,
    input wire logic codecRegisterSelectN,
    output logic sharedBusClaimN,
    output logic hostChannelReady,
    output logic documentWait,
    output logic xcvrEnable,
    output logic xcvrToHost
);
    logic [3:0] grantCount;
    logic [1:0] strobeCount;
    logic waitGiven;
    logic [7:0] lastByte;
    // grant after a chosen delay, withdrawn as soon as the request drops;
    // a grant already given stands, but none is given while the host claims
    always_ff @(posedge clk) begin
        if (srst || !busHoldRequest) begin
            grantCount <= '0;
            busHoldGrant <= 1'b0;
        end else if (grantCount >= grantDelay) begin
            busHoldGrant <= busHoldGrant || sharedBusClaimN;
        end else begin
            grantCount <= grantCount + 4'h1;
        end
    end
    // count strobe cycles so the wait lands on the last data phase
    always_ff @(posedge clk) begin
        if (srst || (memReadN && memWriteN)) begin
            strobeCount <= '0;
            waitGiven <= 1'b0;
        end else begin
            strobeCount <= strobeCount + {1'b0, strobeCount != 2'h3};
            waitGiven <= waitGiven | !memReady;
        end
    end
    // the wait lands on the second strobe clock, the one that would end the access
    assign memReady = !(waitOn && !waitGiven && strobeCount != 2'h0);
    // released lines toggle so a stale byte never passes for data
    always_ff @(posedge clk) begin
        lastByte <= srst ? 8'h00 : upperAddrIn;
    end
    assign upperAddrIn = memReadN ? ~lastByte : readByte;
    // claim latch: one decoded address sets it, another or reset clears it
    always_ff @(posedge clk) begin
        if (srst) begin
            sharedBusClaimN <= 1'b1;
        end else if (claimSet) begin
            sharedBusClaimN <= 1'b0;
        end else if (claimClear) begin
            sharedBusClaimN <= 1'b1;
        end
    end
    // host stalled while it claims the bus and the device still holds its request
    assign hostChannelReady = !(!sharedBusClaimN && busHoldRequest);
    assign documentWait = !sharedBusClaimN;
    // shared transceiver: off for register access, turned only on memory read
    assign xcvrEnable = codecRegisterSelectN;
    assign xcvrToHost = !memReadN && codecRegisterSelectN;
endmodule

// file: csb_system_if_bench.sv
`timescale 1ns/1ps
// ----------------
// bench top
// ----------------
module csb_system_if_bench;
    import csb_pkg::*;
    typedef struct {logic [7:0] idx; logic [7:0] data; logic [7:0] exp;} csb_row_s;
    csb_row_s rows[4] = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h0F, 8'h3C, 8'h3C}, '{8'h10, 8'hFF, 8'h00},
        '{8'h07, 8'h00, 8'h00}};
    logic clk = 0, srst = 1, engineStart = 0, xferWrite = 0, xferDone, codecRegisterSelectN = 1;
    logic slaveReadN = 1, slaveWriteN = 1, slaveDataOe, readyN, readyOe, memReady, busHoldRequest;
    logic busHoldGrant, addrOe, addrLatchEnable, memReadN, memWriteN, waitOn = 0;
    logic [23:0] xferAddr = '0, addrOut;
    logic [7:0] xferWriteData = '0, xferReadData, slaveAddr = '0, slaveDataIn = '0, slaveDataOut;
    logic [7:0] upperAddrIn, readByte = '0, got;
    logic [3:0] grantDelay = '0;
    logic claimSet = 0, claimClear = 0, sharedBusClaimN, hostChannelReady, documentWait, xcvrEnable, xcvrToHost;
    int errors = 0, compares = 0;
    always #10 clk = ~clk;
    csb_system_if i_dut (.clk(clk), .srst(srst), .engineStart(engineStart), .xferWrite(xferWrite),
        .xferAddr(xferAddr), .xferWriteData(xferWriteData), .xferDone(xferDone),
        .xferReadData(xferReadData), .codecRegisterSelectN(codecRegisterSelectN),
        .slaveReadN(slaveReadN), .slaveWriteN(slaveWriteN), .slaveAddr(slaveAddr),
        .slaveDataIn(slaveDataIn), .slaveDataOut(slaveDataOut), .slaveDataOe(slaveDataOe),
        .readyN(readyN), .readyOe(readyOe), .memReady(memReady), .busHoldRequest(busHoldRequest),
        .busHoldGrant(busHoldGrant), .addrOut(addrOut), .addrOe(addrOe), .upperAddrIn(upperAddrIn),
        .addrLatchEnable(addrLatchEnable), .memReadN(memReadN), .memWriteN(memWriteN));
    csb_host_model i_host (.clk(clk), .srst(srst), .busHoldRequest(busHoldRequest),
        .busHoldGrant(busHoldGrant), .memReadN(memReadN), .memWriteN(memWriteN), .memReady(memReady),
        .upperAddrIn(upperAddrIn), .grantDelay(grantDelay), .waitOn(waitOn), .readByte(readByte),
        .claimSet(claimSet), .claimClear(claimClear), .codecRegisterSelectN(codecRegisterSelectN),
        .sharedBusClaimN(sharedBusClaimN), .hostChannelReady(hostChannelReady), .documentWait(documentWait),
        .xcvrEnable(xcvrEnable), .xcvrToHost(xcvrToHost));
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one register access; ready low time is counted, not assumed
    task automatic regAccess(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        int i;
        codecRegisterSelectN = 0;
        slaveWriteN = !wr;
        slaveReadN = wr;
        slaveAddr = idx;
        slaveDataIn = data;
        #1;
        for (i = 0; i < 20 && !readyN; i++) tick;
        if (i == 20) begin
            errors++;
            report_and_stop();
        end
        check("ready low cycles", 24'(i), 24'(SLAVE_BUSY_CYCLES));
        check("ready driven", readyOe, 1);
        check("data drive", slaveDataOe, !wr);
        check("transceiver off", xcvrEnable, 0);
        got = slaveDataOut;
        codecRegisterSelectN = 1;
        slaveWriteN = 1;
        slaveReadN = 1;
        tick;
    endtask
    // one master byte; grant, strobe length and data lanes watched each cycle
    task automatic xfer(input logic wr, input logic [7:0] data, input logic waitIn, input logic [3:0] gd);
        int i, strobes;
        strobes = 0;
        xferWrite = wr;
        xferAddr = {16'h0012, data}; // stays inside one 64 KB page
        xferWriteData = data;
        readByte = ~data;
        waitOn = waitIn;
        grantDelay = gd;
        engineStart = 1;
        tick;
        engineStart = 0;
        tick;
        check("hold request", busHoldRequest, 1);
        for (i = 0; i < 60 && !xferDone; i++) begin
            if ((addrLatchEnable || !memReadN || !memWriteN) && !busHoldGrant) check("grant", 0, 1);
            if (!memReadN || !memWriteN) check("address drive", addrOe, 1);
            if (!memReadN) check("transceiver turned", xcvrToHost, 1);
            strobes += addrLatchEnable || !(memReadN && memWriteN);
            if (!memWriteN) check("upper lane data", addrOut[23:16], data);
            tick;
        end
        if (i == 60) begin
            errors++;
            report_and_stop();
        end
        check("strobe cycles", 24'(strobes), 24'(MEM_ACCESS_CYCLES + waitIn));
        check("hold released", busHoldRequest, 0);
        tick;
        if (!wr) check("read byte", xferReadData, {16'h0000, ~data});
    endtask
    initial begin
        int i;
        repeat (3) tick;
        check("reset ready", readyN, 1);
        check("reset hold", busHoldRequest, 0);
        srst = 0;
        foreach (rows[k]) begin
            regAccess(1, rows[k].idx, rows[k].data);
            regAccess(0, rows[k].idx, 8'h00);
            check("register read", got, rows[k].exp);
        end
        regAccess(0, 8'h00, 8'h00);
        check("index alias", got, 8'hA5);
        xfer(1, 8'h5A, 0, 0);
        xfer(0, 8'hC3, 0, 3);
        xfer(1, 8'h0F, 1, 1);
        xfer(0, 8'hF0, 1, 0);
        // host claims the shared bus; the engine must wait without touching it
        claimSet = 1;
        tick;
        claimSet = 0;
        engineStart = 1;
        tick;
        engineStart = 0;
        repeat (8) begin
            tick;
            check("claimed no access", addrLatchEnable || !memReadN || !memWriteN, 0);
        end
        check("host stalled", hostChannelReady, 0);
        check("document waits", documentWait, 1);
        claimClear = 1;
        tick;
        claimClear = 0;
        for (i = 0; i < 60 && !xferDone; i++) tick;
        if (i == 60) begin
            errors++;
            report_and_stop();
        end
        check("claim released", sharedBusClaimN, 1);
        check("host resumes", hostChannelReady, 1);
        tick;
        check("claimed read byte", xferReadData, 24'h00_000F);
        // reset in mid transfer must drop the request
        engineStart = 1;
        tick;
        engineStart = 0;
        tick;
        srst = 1;
        tick;
        check("hold after reset", busHoldRequest, 0);
        srst = 0;
        repeat (2) tick;
        check("start dropped by reset", busHoldRequest, 0);
        check("ready after reset", readyN, 1);
        check("claim after reset", sharedBusClaimN, 1);
        report_and_stop();
    end
endmodule
